// ==== core/mbw_cfg.svh ====
// Purpose: Constants of the serial write-frame block
// Assumes: 10 MHz system clock
// Notes: Timing counts derive from printed times
`ifndef MBW_CFG_SVH
`define MBW_CFG_SVH
`define MBW_FC_READ 8'h03
`define MBW_FC_WRITE1 8'h06
`define MBW_FC_WRITEN 8'h10
`define MBW_CHAR_START 8'h3A
`define MBW_CHAR_CR 8'h0D
`define MBW_CHAR_LF 8'h0A
`define MBW_CHAR_DIGIT 8'h30
`define MBW_CHAR_DIGIT9 8'h39
`define MBW_CHAR_ALPHA 8'h41
`define MBW_CHAR_ALPHAF 8'h46
`define MBW_HEX_TEN 8'h0A
`define MBW_CRC_INIT 16'hFFFF
`define MBW_CRC_POLY 16'hA001
`define MBW_CRC_BITS 8
`define MBW_MAX_WORDS 16'h000A
`define MBW_HDR_BYTES 6'h06
`define MBW_WRN_HDR 6'h07
`define MBW_RD_HDR 5'h03
`define MBW_BUF_BYTES 32
`define MBW_FIFO_DEPTH 16
`define MBW_FIFO_WIDTH 8
`define MBW_SILENCE_US 10000
`define MBW_CLK_KHZ 10000
`define MBW_SILENCE_CYCLES ((`MBW_SILENCE_US * `MBW_CLK_KHZ + 999) / 1000)
`endif

// ==== core/mbw_pkg.sv ====
// Purpose: Types of the serial write-frame block
// Assumes: Nothing beyond the config header
// Notes: Used with explicit scope only
package mbw_pkg;
    typedef enum logic [3:0] {
        S_RX, S_WRITE, S_WAIT_WR, S_READ, S_WAIT_RD, S_GAP, S_TX_START, S_TX_BODY, S_TX_CHECK, S_TX_END
    } mbw_state_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } mbw_word_t;
endpackage : mbw_pkg

// ==== core/mbw_frame_check.sv ====
// Purpose: Slave framer for word read, single write and multiple write with LRC or CRC-16
// Assumes: Byte UART on the same clock beneath; storage answers each access with a done pulse
// Notes: Response characters pass a 16-entry FIFO towards the UART
// Function
// - In RTU mode the line stays silent 10 ms before and after each frame.
// - Multiple-word writes store word k at the start address plus k.
// - At most ten data words are handled per transaction.
// - The response is sent only after every storage write has completed.
// - ASCII frames carry an LRC byte and RTU frames a CRC-16.
// - The LRC is the two's complement of the byte sum without carry.
// - The CRC accumulator starts at all ones for each frame.
// - Each frame byte is XORed into the accumulator's low byte.
// - Each bit step shifts right and XORs the polynomial when a one fell out.
// - Eight bit steps are done per byte and the final value is the CRC.
// - The CRC low byte is sent first and the high byte second.
// - ASCII frames start with a colon and end with carriage return and line feed.
// - ASCII bytes travel as two hex characters 0-9 and A-F.
// - Function codes read words, write one word and write many words are served.
`timescale 1ns/1ns
`include "mbw_cfg.svh"

module mbw_fifo #(
    parameter int WIDTH = `MBW_FIFO_WIDTH,
    parameter int DEPTH = `MBW_FIFO_DEPTH
) (
    input wire logic clk_i, // System clock
    input wire logic arst_n_i, // Async reset, low
    input wire logic in_valid_i, // Write request
    output logic in_ready_o, // Room available
    input wire logic [WIDTH-1:0] in_data_i, // Write data
    output logic out_valid_o, // Data available
    input wire logic out_ready_i, // Drain request
    output logic [WIDTH-1:0] out_data_o // Head data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wp_reg, rp_reg;
    wire in_fire = in_valid_i && in_ready_o;
    wire out_fire = out_valid_o && out_ready_i;
    assign in_ready_o = (wp_reg - rp_reg) != (AW + 1)'(DEPTH);
    assign out_valid_o = wp_reg != rp_reg;
    assign out_data_o = mem_reg[rp_reg[AW-1:0]];
    always_ff @(posedge clk_i) begin
        if (in_fire) begin
            mem_reg[wp_reg[AW-1:0]] <= in_data_i;
        end
    end
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            wp_reg <= wp_reg + (AW + 1)'(in_fire);
            rp_reg <= rp_reg + (AW + 1)'(out_fire);
        end
    end
endmodule : mbw_fifo

module mbw_frame_check #(
    parameter int SILENCE_CYCLES = `MBW_SILENCE_CYCLES
) (
    input wire logic clk_i, // System clock
    input wire logic arst_n_i, // Async reset, low
    input wire logic ascii_mode_i, // 1 ASCII, 0 RTU
    input wire logic [7:0] station_addr_i, // Own station address
    input wire logic rx_valid_i, // Received byte strobe
    input wire logic [7:0] rx_data_i, // Received byte
    output logic tx_valid_o, // Byte to send
    input wire logic tx_ready_i, // UART takes byte
    output logic [7:0] tx_data_o, // Byte to send
    output logic wr_en_o, // Storage write pulse
    output mbw_pkg::mbw_word_t wr_o, // Write address and data
    input wire logic wr_done_i, // Write completed
    output logic rd_en_o, // Storage read pulse
    output logic [15:0] rd_addr_o, // Read address
    input wire logic rd_valid_i, // Read data valid
    input wire logic [15:0] rd_data_i, // Read data
    output logic frame_ok_o, // Accepted frame pulse
    output logic frame_err_o // Bad own frame pulse
);
    localparam int GW = $clog2(SILENCE_CYCLES + 1);
    localparam logic [GW-1:0] GAP_END = GW'(SILENCE_CYCLES);

    function automatic logic [15:0] mbw_crc_byte(input logic [15:0] crc_in, input logic [7:0] data);
        logic [15:0] c;
        c = crc_in ^ {8'h00, data};
        for (int b = 0; b < `MBW_CRC_BITS; b++) begin
            c = c[0] ? ((c >> 1) ^ `MBW_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : mbw_crc_byte

    mbw_pkg::mbw_state_t state_reg, state_next;
    logic [7:0] buf_reg [`MBW_BUF_BYTES];
    logic [15:0] rdw_reg [10];
    logic [5:0] cnt_reg;
    logic [7:0] sum_reg, tx_sum_reg, fc_reg;
    logic [15:0] crc_reg, tx_crc_reg, base_reg;
    logic [3:0] nib_hi_reg, n_reg, widx_reg;
    logic half_reg, in_frame_reg, cr_reg, bad_reg, ovf_reg;
    logic [GW-1:0] gap_reg;
    logic [4:0] tx_idx_reg;
    logic tx_nib_reg, wr_en_reg, rd_en_reg, ok_reg, err_reg, wr_busy_reg;
    mbw_pkg::mbw_word_t wr_reg;
    logic [15:0] prev_addr_reg;

    // Receive decoding
    wire ascii = ascii_mode_i;
    wire rx_fire = rx_valid_i && (state_reg == mbw_pkg::S_RX);
    wire is_dig = rx_data_i >= `MBW_CHAR_DIGIT && rx_data_i <= `MBW_CHAR_DIGIT9;
    wire is_alpha = rx_data_i >= `MBW_CHAR_ALPHA && rx_data_i <= `MBW_CHAR_ALPHAF;
    wire [7:0] nib_full = is_dig ? rx_data_i - `MBW_CHAR_DIGIT : rx_data_i - `MBW_CHAR_ALPHA + `MBW_HEX_TEN;
    wire a_start = ascii && rx_fire && rx_data_i == `MBW_CHAR_START;
    wire a_lf = rx_fire && in_frame_reg && cr_reg && rx_data_i == `MBW_CHAR_LF;
    wire a_cr = rx_fire && in_frame_reg && rx_data_i == `MBW_CHAR_CR;
    wire a_junk = rx_fire && in_frame_reg && !is_dig && !is_alpha && !a_cr && !a_lf;
    wire gap_done = gap_reg == GAP_END;
    wire byte_stb = ascii ? (rx_fire && in_frame_reg && (is_dig || is_alpha) && half_reg) : rx_fire;
    wire [7:0] byte_val = ascii ? {nib_hi_reg, nib_full[3:0]} : rx_data_i;
    wire frame_end = ascii ? (ascii && a_lf) : (state_reg == mbw_pkg::S_RX && cnt_reg != 6'h00 && gap_done);
    wire rx_clr = frame_end || a_start || state_reg != mbw_pkg::S_RX;

    // Frame evaluation
    wire [5:0] body = cnt_reg - (ascii ? 6'h01 : 6'h02);
    wire [7:0] fc = buf_reg[1];
    wire [15:0] nwords = {buf_reg[4], buf_reg[5]};
    wire nw_ok = nwords != 16'h0000 && nwords <= `MBW_MAX_WORDS;
    wire wrn_ok = nw_ok && buf_reg[6] == {nwords[6:0], 1'b0} && body == `MBW_WRN_HDR + buf_reg[6][5:0];
    wire len_ok = (fc == `MBW_FC_WRITE1) ? body == `MBW_HDR_BYTES :
                  (fc == `MBW_FC_READ) ? (body == `MBW_HDR_BYTES && nw_ok) :
                  (fc == `MBW_FC_WRITEN) ? wrn_ok : 1'b0;
    // LRC for ASCII, CRC for RTU
    wire chk_ok = ascii ? sum_reg == 8'h00 : crc_reg == 16'h0000;
    wire mine = buf_reg[0] == station_addr_i;
    wire good = chk_ok && len_ok && mine && !bad_reg && !ovf_reg && !(ascii && half_reg);

    // Storage access
    wire is_read = fc_reg == `MBW_FC_READ;
    wire [4:0] di = 5'h07 + {widx_reg, 1'b0};
    wire last_word = widx_reg + 4'h1 == n_reg;
    wire [15:0] wdata = (fc_reg == `MBW_FC_WRITE1) ? {buf_reg[4], buf_reg[5]} : {buf_reg[di], buf_reg[di + 5'h01]};

    // Response building
    wire [4:0] resp_len = is_read ? `MBW_RD_HDR + {n_reg, 1'b0} : 5'h06;
    wire [4:0] ri = tx_idx_reg - `MBW_RD_HDR;
    wire [15:0] rword = rdw_reg[ri[4:1]];
    wire [7:0] rd_byte = (tx_idx_reg == 5'h02) ? {3'h0, n_reg, 1'b0} : (ri[0] ? rword[7:0] : rword[15:8]);
    wire [7:0] resp_byte = (is_read && tx_idx_reg >= 5'h02) ? rd_byte : buf_reg[tx_idx_reg];
    wire [7:0] lrc_val = ~tx_sum_reg + 8'h01;
    wire [7:0] chk_byte = ascii ? lrc_val : (tx_idx_reg[0] ? tx_crc_reg[15:8] : tx_crc_reg[7:0]);
    wire in_body = state_reg == mbw_pkg::S_TX_BODY;
    wire in_chk = state_reg == mbw_pkg::S_TX_CHECK;
    wire [7:0] cur_byte = in_body ? resp_byte : chk_byte;
    wire [3:0] nib = tx_nib_reg ? cur_byte[3:0] : cur_byte[7:4];
    wire [7:0] hex_ch = (nib < 4'hA) ? `MBW_CHAR_DIGIT + {4'h0, nib} : `MBW_CHAR_ALPHA - `MBW_HEX_TEN + {4'h0, nib};
    wire push_valid = in_body || in_chk || state_reg == mbw_pkg::S_TX_END || (state_reg == mbw_pkg::S_TX_START && ascii);
    wire [7:0] push_data = (state_reg == mbw_pkg::S_TX_START) ? `MBW_CHAR_START :
                           (state_reg == mbw_pkg::S_TX_END) ? (tx_idx_reg[0] ? `MBW_CHAR_LF : `MBW_CHAR_CR) :
                           ascii ? hex_ch : cur_byte;
    wire push_ready;
    wire push_fire = push_valid && push_ready;
    wire byte_done = push_fire && (in_body || in_chk) && (!ascii || tx_nib_reg);
    wire body_last = byte_done && in_body && tx_idx_reg == resp_len - 5'h01;
    wire chk_last = byte_done && in_chk && (ascii || tx_idx_reg[0]);
    wire end_last = push_fire && state_reg == mbw_pkg::S_TX_END && tx_idx_reg[0];

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            mbw_pkg::S_RX: if (frame_end && good) state_next = (fc == `MBW_FC_READ) ? mbw_pkg::S_READ : mbw_pkg::S_WRITE;
            mbw_pkg::S_WRITE: state_next = mbw_pkg::S_WAIT_WR;
            mbw_pkg::S_WAIT_WR: if (wr_done_i) state_next = last_word ? mbw_pkg::S_GAP : mbw_pkg::S_WRITE;
            mbw_pkg::S_READ: state_next = mbw_pkg::S_WAIT_RD;
            mbw_pkg::S_WAIT_RD: if (rd_valid_i) state_next = last_word ? mbw_pkg::S_GAP : mbw_pkg::S_READ;
            mbw_pkg::S_GAP: if (ascii || gap_done) state_next = mbw_pkg::S_TX_START;
            mbw_pkg::S_TX_START: if (!ascii || push_ready) state_next = mbw_pkg::S_TX_BODY;
            mbw_pkg::S_TX_BODY: if (body_last) state_next = mbw_pkg::S_TX_CHECK;
            mbw_pkg::S_TX_CHECK: if (chk_last) state_next = ascii ? mbw_pkg::S_TX_END : mbw_pkg::S_RX;
            mbw_pkg::S_TX_END: if (end_last) state_next = mbw_pkg::S_RX;
            default: state_next = mbw_pkg::S_RX;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (byte_stb && !cnt_reg[5]) begin
            buf_reg[cnt_reg[4:0]] <= byte_val;
        end
        if (state_reg == mbw_pkg::S_WAIT_RD && rd_valid_i) begin
            rdw_reg[widx_reg] <= rd_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= '0;
            sum_reg <= '0;
            crc_reg <= `MBW_CRC_INIT;
            ovf_reg <= 1'b0;
        end else if (rx_clr) begin
            cnt_reg <= '0;
            sum_reg <= '0;
            crc_reg <= `MBW_CRC_INIT;
            ovf_reg <= 1'b0;
        end else if (byte_stb) begin
            cnt_reg <= cnt_reg[5] ? cnt_reg : cnt_reg + 6'h01;
            ovf_reg <= ovf_reg || cnt_reg[5];
            sum_reg <= sum_reg + byte_val;
            crc_reg <= mbw_crc_byte(crc_reg, byte_val);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            in_frame_reg <= 1'b0;
            half_reg <= 1'b0;
            cr_reg <= 1'b0;
            bad_reg <= 1'b0;
            nib_hi_reg <= '0;
        end else if (a_start) begin
            in_frame_reg <= 1'b1;
            half_reg <= 1'b0;
            cr_reg <= 1'b0;
            bad_reg <= 1'b0;
        end else if (frame_end || state_reg != mbw_pkg::S_RX) begin
            in_frame_reg <= 1'b0;
        end else if (rx_fire && in_frame_reg) begin
            cr_reg <= a_cr;
            bad_reg <= bad_reg || a_junk || (cr_reg && !a_lf);
            half_reg <= (is_dig || is_alpha) ? !half_reg : half_reg;
            nib_hi_reg <= nib_full[3:0];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            gap_reg <= '0;
        end else if (rx_valid_i || (tx_valid_o && tx_ready_i)) begin
            gap_reg <= '0;
        end else if (!gap_done) begin
            gap_reg <= gap_reg + GW'(1);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_reg <= mbw_pkg::S_RX;
            fc_reg <= '0;
            base_reg <= '0;
            n_reg <= '0;
            widx_reg <= '0;
            ok_reg <= 1'b0;
            err_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ok_reg <= frame_end && good;
            err_reg <= frame_end && mine && !good;
            if (frame_end && good) begin
                fc_reg <= fc;
                base_reg <= {buf_reg[2], buf_reg[3]};
                n_reg <= (fc == `MBW_FC_WRITE1) ? 4'h1 : nwords[3:0];
                widx_reg <= '0;
            end else if ((state_reg == mbw_pkg::S_WAIT_WR && wr_done_i) || (state_reg == mbw_pkg::S_WAIT_RD && rd_valid_i)) begin
                widx_reg <= widx_reg + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_en_reg <= 1'b0;
            rd_en_reg <= 1'b0;
            wr_reg <= '0;
            wr_busy_reg <= 1'b0;
            prev_addr_reg <= '0;
        end else begin
            wr_en_reg <= state_reg == mbw_pkg::S_WRITE;
            rd_en_reg <= state_reg == mbw_pkg::S_READ;
            wr_busy_reg <= (state_reg == mbw_pkg::S_WRITE) || (wr_busy_reg && !wr_done_i);
            if (wr_en_reg) begin
                prev_addr_reg <= wr_reg.addr;
            end
            if (state_reg == mbw_pkg::S_WRITE || state_reg == mbw_pkg::S_READ) begin
                wr_reg.addr <= base_reg + {12'h000, widx_reg};
                wr_reg.data <= wdata;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_idx_reg <= '0;
            tx_nib_reg <= 1'b0;
            tx_sum_reg <= '0;
            tx_crc_reg <= `MBW_CRC_INIT;
        end else begin
            tx_idx_reg <= (state_next != state_reg) ? 5'h00 : tx_idx_reg + 5'((byte_done && !body_last) || (push_fire && state_reg == mbw_pkg::S_TX_END));
            tx_nib_reg <= (push_fire && ascii && (in_body || in_chk)) ? !tx_nib_reg : tx_nib_reg;
            if (state_reg == mbw_pkg::S_GAP) begin
                tx_sum_reg <= '0;
                tx_crc_reg <= `MBW_CRC_INIT;
            end else if (byte_done && in_body) begin
                tx_sum_reg <= tx_sum_reg + resp_byte;
                tx_crc_reg <= mbw_crc_byte(tx_crc_reg, resp_byte);
            end
        end
    end

    mbw_fifo #(.WIDTH(`MBW_FIFO_WIDTH), .DEPTH(`MBW_FIFO_DEPTH)) u_txq (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(push_valid),
        .in_ready_o(push_ready),
        .in_data_i(push_data),
        .out_valid_o(tx_valid_o),
        .out_ready_i(tx_ready_i),
        .out_data_o(tx_data_o)
    );

    assign wr_en_o = wr_en_reg;
    assign wr_o = wr_reg;
    assign rd_en_o = rd_en_reg;
    assign rd_addr_o = wr_reg.addr;
    assign frame_ok_o = ok_reg;
    assign frame_err_o = err_reg;

    sequence s_resp_start;
        state_reg == mbw_pkg::S_GAP ##1 state_reg == mbw_pkg::S_TX_START;
    endsequence
    property p_gap_before_tx;
        @(posedge clk_i) disable iff (!arst_n_i) !ascii ##0 s_resp_start |-> $past(gap_done);
    endproperty
    a_gap_before_tx: assert property (p_gap_before_tx) else $error("reply started before silence");
    property p_addr_step;
        @(posedge clk_i) disable iff (!arst_n_i) wr_en_o && widx_reg != 4'h0 |-> wr_o.addr == prev_addr_reg + 16'h0001;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("write address not consecutive");
    property p_max_words;
        @(posedge clk_i) disable iff (!arst_n_i) wr_en_o |-> widx_reg < 4'hA;
    endproperty
    a_max_words: assert property (p_max_words) else $error("more than ten words written");
    property p_write_first;
        @(posedge clk_i) disable iff (!arst_n_i) s_resp_start |-> !wr_busy_reg;
    endproperty
    a_write_first: assert property (p_write_first) else $error("reply before write done");
    property p_ascii_one_chk;
        @(posedge clk_i) disable iff (!arst_n_i) in_chk && ascii |-> tx_idx_reg == 5'h00;
    endproperty
    a_ascii_one_chk: assert property (p_ascii_one_chk) else $error("ASCII check longer than one byte");
    property p_crc_init;
        @(posedge clk_i) disable iff (!arst_n_i) byte_stb && !ascii && cnt_reg == 6'h00 |-> crc_reg == 16'hFFFF;
    endproperty
    a_crc_init: assert property (p_crc_init) else $error("CRC not all ones at frame start");
    property p_crc_lo_first;
        @(posedge clk_i) disable iff (!arst_n_i) push_fire && in_chk && !ascii |-> push_data == (tx_idx_reg[0] ? tx_crc_reg[15:8] : tx_crc_reg[7:0]) ##1 $stable(tx_crc_reg);
    endproperty
    a_crc_lo_first: assert property (p_crc_lo_first) else $error("CRC byte order wrong");
    property p_resp_len;
        @(posedge clk_i) disable iff (!arst_n_i) $rose(in_chk) && !is_read |-> $past(tx_idx_reg) == 5'h05;
    endproperty
    a_resp_len: assert property (p_resp_len) else $error("write reply length not six");
    property p_frame_tail;
        @(posedge clk_i) disable iff (!arst_n_i) push_fire && state_reg == mbw_pkg::S_TX_END && !tx_idx_reg[0] |-> push_data == 8'h0D ##[1:20] (push_fire && push_data == 8'h0A);
    endproperty
    a_frame_tail: assert property (p_frame_tail) else $error("ASCII tail not CR LF");
    property p_hex_chars;
        @(posedge clk_i) disable iff (!arst_n_i) push_valid && ascii && (in_body || in_chk) |-> (push_data >= 8'h30 && push_data <= 8'h39) || (push_data >= 8'h41 && push_data <= 8'h46);
    endproperty
    a_hex_chars: assert property (p_hex_chars) else $error("non hex character sent");
    property p_fc_served;
        @(posedge clk_i) disable iff (!arst_n_i) frame_ok_o |-> fc_reg == 8'h03 || fc_reg == 8'h06 || fc_reg == 8'h10;
    endproperty
    a_fc_served: assert property (p_fc_served) else $error("unknown function accepted");
endmodule : mbw_frame_check

// ==== verification/mbw_far_model.sv ====
// Purpose: Storage and UART sink beside the frame block
// Assumes: One clock, async low reset
// Notes: Stalls the UART side periodically; write done comes late
`timescale 1ns/1ns
module mbw_far_model (
    input wire logic clk_i, // System clock
    input wire logic arst_n_i, // Async reset, low
    input wire logic wr_en_i, // Storage write pulse
    output logic wr_done_o, // Write completed
    input wire logic rd_en_i, // Storage read pulse
    input wire logic [15:0] rd_addr_i, // Read address
    output logic rd_valid_o, // Read data valid
    output logic [15:0] rd_data_o, // Read data
    output logic tx_ready_o // UART takes byte
);
    logic [2:0] wr_dly_reg;
    logic [7:0] cnt_reg;
    // Stall one cycle in eight
    assign tx_ready_o = (cnt_reg[2:0] != 3'h0);
    assign wr_done_o = wr_dly_reg[2];
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_dly_reg <= 3'h0;
            cnt_reg <= 8'h00;
            rd_valid_o <= 1'b0;
            rd_data_o <= 16'h0000;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
            wr_dly_reg <= {wr_dly_reg[1:0], wr_en_i};
            rd_valid_o <= rd_en_i;
            // Read word is the inverted address; junk otherwise
            rd_data_o <= rd_en_i ? ~rd_addr_i : {cnt_reg, ~cnt_reg};
        end
    end
endmodule : mbw_far_model

// ==== verification/mbw_frame_check_bench.sv ====
// Purpose: Self-checking bench of the write-frame block
// Assumes: Short silence parameter of 50 cycles
// Notes: Expected bytes and writes are queued by the driver
`timescale 1ns/1ns
module mbw_frame_check_bench;
    typedef logic [7:0] mbw_bytes_t[$];
    logic clk_i = 1'b0;
    logic arst_n_i, ascii_mode_i, rx_valid_i;
    logic [7:0] station_addr_i, rx_data_i, tx_data_o;
    logic tx_valid_o, tx_ready_i, wr_en_o, wr_done_i, rd_en_o, rd_valid_i, frame_ok_o, frame_err_o;
    logic [15:0] rd_addr_o, rd_data_i, a;
    mbw_pkg::mbw_word_t wr_o;
    logic [31:0] exp_wr[$];
    logic [7:0] exp_tx[$];
    mbw_bytes_t b;
    int num_errors = 0, compares = 0, err_cnt = 0, exp_err = 0, pend = 0, seed = 54, ok_cnt = 0;
    always #50 clk_i = ~clk_i;
    mbw_frame_check #(.SILENCE_CYCLES(50)) mbw_frame_check_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .ascii_mode_i(ascii_mode_i), .station_addr_i(station_addr_i), .rx_valid_i(rx_valid_i),
        .rx_data_i(rx_data_i), .tx_valid_o(tx_valid_o), .tx_ready_i(tx_ready_i), .tx_data_o(tx_data_o),
        .wr_en_o(wr_en_o), .wr_o(wr_o), .wr_done_i(wr_done_i), .rd_en_o(rd_en_o), .rd_addr_o(rd_addr_o),
        .rd_valid_i(rd_valid_i), .rd_data_i(rd_data_i), .frame_ok_o(frame_ok_o), .frame_err_o(frame_err_o));
    mbw_far_model mbw_far_model_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .wr_en_i(wr_en_o),
        .wr_done_o(wr_done_i), .rd_en_i(rd_en_o), .rd_addr_i(rd_addr_o), .rd_valid_o(rd_valid_i),
        .rd_data_o(rd_data_i), .tx_ready_o(tx_ready_i));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
    endfunction : hx
    // Append check and, in ASCII, encode as characters
    function automatic mbw_bytes_t enc(input bit asc, input mbw_bytes_t d);
        logic [15:0] c;
        logic [7:0] s;
        mbw_bytes_t o;
        c = 16'hFFFF;
        s = 8'h00;
        foreach (d[i]) begin
            s += d[i];
            c ^= {8'h00, d[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        if (asc) begin
            s = -s;
            o.push_back(8'h3A);
            foreach (d[i]) begin
                o.push_back(hx(d[i][7:4]));
                o.push_back(hx(d[i][3:0]));
            end
            o.push_back(hx(s[7:4]));
            o.push_back(hx(s[3:0]));
            o.push_back(8'h0D);
            o.push_back(8'h0A);
        end else begin
            o = d;
            o.push_back(c[7:0]);
            o.push_back(c[15:8]);
        end
        return o;
    endfunction : enc
    task automatic send(input bit asc, input mbw_bytes_t d, input bit bad);
        mbw_bytes_t o;
        o = enc(asc, d);
        if (bad) o[o.size() - 1] ^= 8'h01;
        ascii_mode_i <= asc;
        foreach (o[i]) begin
            @(posedge clk_i) rx_valid_i <= 1'b1;
            rx_data_i <= o[i];
            @(posedge clk_i) rx_valid_i <= 1'b0;
        end
    endtask : send
    task automatic expect_reply(input bit asc, input mbw_bytes_t d);
        mbw_bytes_t o;
        o = enc(asc, d);
        foreach (o[i]) exp_tx.push_back(o[i]);
    endtask : expect_reply
    task automatic settle();
        for (int n = 0; n < 3000 && (exp_tx.size() != 0 || exp_wr.size() != 0); n++) @(posedge clk_i);
        chk("queues drained", exp_tx.size() + exp_wr.size(), 0);
        repeat (80) @(posedge clk_i);
    endtask : settle
    always @(posedge clk_i) begin
        if (arst_n_i) begin
            pend = pend + int'(wr_en_o) - int'(wr_done_i);
            if (frame_err_o === 1'b1) err_cnt++;
            if (frame_ok_o === 1'b1) ok_cnt++;
            if (tx_valid_o === 1'b1 && tx_ready_i) begin
                chk("reply before write done", pend, 0);
                if (exp_tx.size() == 0) chk("extra reply byte", 1, 0);
                else chk("reply byte", tx_data_o, exp_tx.pop_front());
            end
            if (wr_en_o === 1'b1) begin
                if (exp_wr.size() == 0) chk("extra write", 1, 0);
                else chk("write", wr_o, exp_wr.pop_front());
            end
        end
    end
    task automatic finish_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (60000) @(posedge clk_i);
        num_errors++;
        finish_test();
    end
    initial begin
        arst_n_i = 1'b0;
        ascii_mode_i = 1'b0;
        rx_valid_i = 1'b0;
        station_addr_i = 8'h01;
        rx_data_i = 8'h00;
        repeat (12) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (60) @(posedge clk_i);
        exp_wr.push_back(32'h02000064);
        expect_reply(0, '{8'h01, 8'h06, 8'h02, 8'h00, 8'h00, 8'h64});
        send(0, '{8'h01, 8'h06, 8'h02, 8'h00, 8'h00, 8'h64}, 0);
        settle();
        exp_wr.push_back(32'h01120BB8);
        exp_wr.push_back(32'h01130000);
        expect_reply(0, '{8'h01, 8'h10, 8'h01, 8'h12, 8'h00, 8'h02});
        send(0, '{8'h01, 8'h10, 8'h01, 8'h12, 8'h00, 8'h02, 8'h04, 8'h0B, 8'hB8, 8'h00, 8'h00}, 0);
        settle();
        exp_wr.push_back(32'h02000064);
        expect_reply(1, '{8'h01, 8'h06, 8'h02, 8'h00, 8'h00, 8'h64});
        send(1, '{8'h01, 8'h06, 8'h02, 8'h00, 8'h00, 8'h64}, 0);
        settle();
        // ten random words, then eleven refused
        a = 16'h7FFF & 16'($random(seed));
        b = '{8'h01, 8'h10, a[15:8], a[7:0], 8'h00, 8'h0A, 8'h14};
        expect_reply(0, b[0:5]);
        for (int k = 0; k < 10; k++) begin
            exp_wr.push_back({a + 16'(k), 16'($random(seed))});
            b.push_back(exp_wr[k][15:8]);
            b.push_back(exp_wr[k][7:0]);
        end
        send(0, b, 0);
        settle();
        b[5] = 8'h0B;
        b[6] = 8'h16;
        b.push_back(8'h12);
        b.push_back(8'h34);
        exp_err++;
        send(0, b, 0);
        settle();
        expect_reply(0, '{8'h01, 8'h03, 8'h02, 8'hFD, 8'hFF});
        send(0, '{8'h01, 8'h03, 8'h02, 8'h00, 8'h00, 8'h01}, 0);
        settle();
        // bad check refused; other station ignored
        exp_err++;
        send(0, '{8'h01, 8'h06, 8'h02, 8'h00, 8'h00, 8'h64}, 1);
        settle();
        send(0, '{8'h02, 8'h06, 8'h02, 8'h00, 8'h00, 8'h64}, 0);
        settle();
        station_addr_i <= 8'h02;
        exp_wr.push_back(32'h02000064);
        expect_reply(0, '{8'h02, 8'h06, 8'h02, 8'h00, 8'h00, 8'h64});
        send(0, '{8'h02, 8'h06, 8'h02, 8'h00, 8'h00, 8'h64}, 0);
        settle();
        chk("frame errors", err_cnt, exp_err);
        chk("frames accepted", ok_cnt, 6);
        finish_test();
    end
endmodule : mbw_frame_check_bench
